/* File: inc/nv_host_map.svh */
/*
 Named constants for the host-side controller of a byte-wide nonvolatile SRAM.
 Assumes a 50 MHz core clock; timing figures are in nanoseconds.
*/
`ifndef NV_HOST_MAP_SVH
`define NV_HOST_MAP_SVH

`define NV_ADDR_W           17
`define NV_DATA_W           8
`define NV_CLK_PERIOD_NS    20
// Address setup before strobes fall
`define NV_SETUP_NS         40
// Strobe low time for read and write
`define NV_ACCESS_NS        60
// Hold after strobes rise
`define NV_HOLD_NS          20
// Wait after a store request before the store is assumed started
`define NV_STORE_REQ_DELAY_NS 100
`define NV_CYC(ns)          ((((ns) + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS))
`define NV_CNT_W            8
`define NV_SW_SEQ_LEN       6
`define NV_SW_A0            17'h04e38
`define NV_SW_A1            17'h0b1c7
`define NV_SW_A2            17'h083e0
`define NV_SW_A3            17'h07c1f
`define NV_SW_A4            17'h0703f
`define NV_SW_STORE         17'h08fc0

`endif

/* File: inc/nv_host_pkg.sv */
/*
 Types for the host-side nonvolatile SRAM controller.
 Assumes nv_host_map.svh supplies widths.
*/
`include "nv_host_map.svh"
package nv_host_pkg;
	typedef enum logic [5:0]
	{
		ST_IDLE  = 6'b000001,
		ST_SETUP = 6'b000010,
		ST_ACT   = 6'b000100,
		ST_HOLD  = 6'b001000,
		ST_HSREQ = 6'b010000,
		ST_BUSY  = 6'b100000
	} host_state_t;

	typedef enum logic [1:0]
	{
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_SWST  = 2'h2,
		OP_HWST  = 2'h3
	} host_op_t;

	typedef struct packed
	{
		host_op_t                 op;
		logic [`NV_ADDR_W-1:0]    addr;
		logic [`NV_DATA_W-1:0]    wdata;
	} host_req_t;

	typedef struct packed
	{
		logic                     chip_sel_n;
		logic                     write_n;
		logic                     out_drive_n;
	} mem_ctl_t;
endpackage : nv_host_pkg

/* File: rtl/nv_sram_store_port.sv */
/*
 Host-side controller for an asynchronous byte-wide SRAM with a nonvolatile
 shadow: runs read, write, software-store and pin-requested store cycles.
 Assumes the memory pins are wired directly; store_busy_n is open drain with
 a pull-up on the board, and data_io is resolved by the testbench.
*/
// Contract
// - Data lines shared; host drives only while writing.
// - Write needs store-busy high; host holds address until strobes rise.
// - Host keeps output-drive high throughout every write.
// - Store-busy pin optional; pull-up needed if shared.
// - Six fixed-address reads trigger a software store.
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_map.svh"
module nv_sram_store_port
	import nv_host_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_req_valid,
	input  wire host_req_t             i_req,
	output logic                       o_req_ready,
	output logic                       o_rsp_valid,
	output logic [`NV_DATA_W-1:0]      o_rsp_data,
	output logic                       o_dirty,
	output logic                       o_store_busy,
	input  wire logic                  i_power_fail,
	output logic [`NV_ADDR_W-1:0]      o_addr_in,
	output logic                       o_chip_sel_n,
	output logic                       o_write_n,
	output logic                       o_out_drive_n,
	input  wire logic [`NV_DATA_W-1:0] i_data_io,
	output logic [`NV_DATA_W-1:0]      o_data_io,
	output logic                       o_data_io_oe_n,
	input  wire logic                  i_store_busy_n,
	output logic                       o_store_busy_n,
	output logic                       o_store_busy_n_oe_n
);

	localparam logic [`NV_CNT_W-1:0] SETUP_CYC = `NV_CNT_W'(`NV_CYC(`NV_SETUP_NS));
	localparam logic [`NV_CNT_W-1:0] ACC_CYC   = `NV_CNT_W'(`NV_CYC(`NV_ACCESS_NS));
	localparam logic [`NV_CNT_W-1:0] HOLD_CYC  = `NV_CNT_W'(`NV_CYC(`NV_HOLD_NS));
	localparam logic [`NV_CNT_W-1:0] DLY_CYC   = `NV_CNT_W'(`NV_CYC(`NV_STORE_REQ_DELAY_NS));
	logic [1:0] rst_sync_r;
	logic       rst_n;
	always_ff @(posedge i_core_clk or negedge i_reset_n)
		if (!i_reset_n)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	assign rst_n = rst_sync_r[1];
	// Pin synchronisers
	logic [1:0]                  busy_sync_r;
	logic [1:0]                  pf_sync_r;
	logic [`NV_DATA_W-1:0]       dq_meta_r;
	logic [`NV_DATA_W-1:0]       dq_sync_r;
	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_sync_r <= 2'h3;
			pf_sync_r   <= 2'h0;
			dq_meta_r   <= `NV_DATA_W'h0;
			dq_sync_r   <= `NV_DATA_W'h0;
		end
		else
		begin
			busy_sync_r <= {busy_sync_r[0], i_store_busy_n};
			pf_sync_r   <= {pf_sync_r[0], i_power_fail};
			dq_meta_r   <= i_data_io;
			dq_sync_r   <= dq_meta_r;
		end
	end
	logic busy_low;
	assign busy_low = ~busy_sync_r[1];
	host_state_t                 state_r, state_nxt;
	host_req_t                   req_r, req_nxt;
	mem_ctl_t                    ctl_r, ctl_nxt;
	logic [`NV_CNT_W-1:0]        cnt_r, cnt_nxt;
	logic [2:0]                  seq_r, seq_nxt;
	logic                        drive_r, drive_nxt;
	logic                        hs_pull_r, hs_pull_nxt;
	logic                        ready_r, ready_nxt;
	logic                        rsp_v_r, rsp_v_nxt;
	logic [`NV_DATA_W-1:0]       rsp_d_r, rsp_d_nxt;
	logic                        dirty_r, dirty_nxt;
	logic                        sbusy_r, sbusy_nxt;
	function automatic logic [`NV_ADDR_W-1:0] seq_addr(input logic [2:0] i);
		unique case (i)
			3'h0: seq_addr = `NV_SW_A0;
			3'h1: seq_addr = `NV_SW_A1;
			3'h2: seq_addr = `NV_SW_A2;
			3'h3: seq_addr = `NV_SW_A3;
			3'h4: seq_addr = `NV_SW_A4;
			default: seq_addr = `NV_SW_STORE;
		endcase
	endfunction : seq_addr
	always_comb
	begin
		state_nxt   = state_r;
		req_nxt     = req_r;
		ctl_nxt     = ctl_r;
		cnt_nxt     = cnt_r;
		seq_nxt     = seq_r;
		drive_nxt   = drive_r;
		hs_pull_nxt = hs_pull_r;
		ready_nxt   = 1'b0;
		rsp_v_nxt   = 1'b0;
		rsp_d_nxt   = rsp_d_r;
		dirty_nxt   = dirty_r;
		sbusy_nxt   = busy_low | (state_r == ST_BUSY);
		unique case (state_r)
			ST_IDLE:
			begin
				ctl_nxt = '{chip_sel_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1};
				if (busy_low || pf_sync_r[1])
				begin
					state_nxt = ST_BUSY;
					dirty_nxt = dirty_r & ~pf_sync_r[1];
				end
				else if (i_req_valid && ready_r)
				begin
					req_nxt = i_req;
					seq_nxt = (i_req.op == OP_SWST) ? 3'h1 : 3'h0;
					if (i_req.op == OP_SWST)
					begin
						req_nxt.op   = OP_READ;
						req_nxt.addr = seq_addr(3'h0);
					end
					if (i_req.op == OP_HWST)
					begin
						hs_pull_nxt = 1'b1;
						cnt_nxt     = DLY_CYC;
						state_nxt   = ST_HSREQ;
						dirty_nxt   = 1'b0;
					end
					else
					begin
						cnt_nxt   = SETUP_CYC;
						state_nxt = ST_SETUP;
					end
				end
				else
					ready_nxt = 1'b1;
			end
			ST_SETUP:
			begin
				if (cnt_r > `NV_CNT_W'h1)
					cnt_nxt = cnt_r - `NV_CNT_W'h1;
				else
				begin
					cnt_nxt   = ACC_CYC;
					state_nxt = ST_ACT;
					ctl_nxt.chip_sel_n = 1'b0;
					if (req_r.op == OP_WRITE)
					begin
						ctl_nxt.write_n = 1'b0;
						drive_nxt       = 1'b1;
					end
					else
						ctl_nxt.out_drive_n = 1'b0;
				end
			end
			ST_ACT:
			begin
				if (cnt_r > `NV_CNT_W'h1)
					cnt_nxt = cnt_r - `NV_CNT_W'h1;
				else
				begin
					ctl_nxt   = '{chip_sel_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1};
					cnt_nxt   = HOLD_CYC;
					state_nxt = ST_HOLD;
					if (req_r.op == OP_READ)
						rsp_d_nxt = dq_sync_r;
					else if (!busy_low)
						dirty_nxt = 1'b1;
				end
			end
			ST_HOLD:
			begin
				if (cnt_r > `NV_CNT_W'h1)
					cnt_nxt = cnt_r - `NV_CNT_W'h1;
				else
				begin
					drive_nxt = 1'b0;
					if (seq_r != 3'h0 && seq_r < 3'(`NV_SW_SEQ_LEN))
					begin
						req_nxt.addr = seq_addr(seq_r);
						seq_nxt      = seq_r + 3'h1;
						cnt_nxt      = SETUP_CYC;
						state_nxt    = ST_SETUP;
					end
					else if (seq_r == 3'(`NV_SW_SEQ_LEN))
					begin
						seq_nxt   = 3'h0;
						dirty_nxt = 1'b0;
						cnt_nxt   = DLY_CYC;
						state_nxt = ST_HSREQ;
					end
					else
					begin
						rsp_v_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_HSREQ:
			begin
				if (cnt_r > `NV_CNT_W'h1)
					cnt_nxt = cnt_r - `NV_CNT_W'h1;
				else
				begin
					hs_pull_nxt = 1'b0;
					state_nxt   = ST_BUSY;
				end
			end
			ST_BUSY:
			begin
				if (!busy_low && !pf_sync_r[1])
				begin
					rsp_v_nxt = (req_r.op == OP_HWST) || (seq_r == 3'h0 && req_r.op == OP_READ
						&& req_r.addr == `NV_SW_STORE);
					state_nxt = ST_IDLE;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= ST_IDLE;
			req_r     <= '0;
			ctl_r     <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_drive_n: 1'b1};
			cnt_r     <= `NV_CNT_W'h0;
			seq_r     <= 3'h0;
			drive_r   <= 1'b0;
			hs_pull_r <= 1'b0;
			ready_r   <= 1'b0;
			rsp_v_r   <= 1'b0;
			rsp_d_r   <= `NV_DATA_W'h0;
			dirty_r   <= 1'b0;
			sbusy_r   <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			req_r     <= req_nxt;
			ctl_r     <= ctl_nxt;
			cnt_r     <= cnt_nxt;
			seq_r     <= seq_nxt;
			drive_r   <= drive_nxt;
			hs_pull_r <= hs_pull_nxt;
			ready_r   <= ready_nxt;
			rsp_v_r   <= rsp_v_nxt;
			rsp_d_r   <= rsp_d_nxt;
			dirty_r   <= dirty_nxt;
			sbusy_r   <= sbusy_nxt;
		end
	end
	assign o_req_ready         = ready_r;
	assign o_rsp_valid         = rsp_v_r;
	assign o_rsp_data          = rsp_d_r;
	assign o_dirty             = dirty_r;
	assign o_store_busy        = sbusy_r;
	assign o_addr_in           = req_r.addr;
	assign o_chip_sel_n        = ctl_r.chip_sel_n;
	assign o_write_n           = ctl_r.write_n;
	assign o_out_drive_n       = ctl_r.out_drive_n;
	assign o_data_io           = req_r.wdata;
	assign o_data_io_oe_n      = ~drive_r;
	assign o_store_busy_n      = 1'b0;
	assign o_store_busy_n_oe_n = ~hs_pull_r;
endmodule : nv_sram_store_port
`default_nettype wire

/* File: bench/nv_sram_store_port_assertions.sv */
/* Checker for the host pins of the nonvolatile SRAM controller.
 Assumes a bind from the bench top file. */
`timescale 1ns/100ps
`default_nettype none
module nv_sram_store_port_assertions
	import nv_host_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_reset_n,
	input wire logic        i_power_fail,
	input wire logic        i_store_busy_n,
	input wire logic        o_req_ready,
	input wire logic [16:0] o_addr_in,
	input wire logic        o_chip_sel_n,
	input wire logic        o_write_n,
	input wire logic        o_out_drive_n,
	input wire logic        o_data_io_oe_n,
	input wire logic        o_store_busy_n_oe_n
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	a_oe_high_write: assert property (!o_write_n |-> o_out_drive_n)
		else $error("output drive low in write");
	a_host_drive_only: assert property (!o_data_io_oe_n |-> o_out_drive_n)
		else $error("host drives data during read");
	a_write_drive: assert property (!o_write_n |-> !o_data_io_oe_n && !o_chip_sel_n)
		else $error("write without data or select");
	a_addr_stable: assert property (!o_chip_sel_n && !$past(o_chip_sel_n) |->
		$stable(o_addr_in))
		else $error("address moved in cycle");
	a_read_window: assert property ($fell(o_out_drive_n) |->
		(!o_chip_sel_n && !o_out_drive_n)[*3] ##1 (o_chip_sel_n && o_out_drive_n))
		else $error("read strobe length wrong");
	a_write_window: assert property ($fell(o_write_n) |->
		(!o_write_n)[*3] ##1 (o_write_n && !o_data_io_oe_n))
		else $error("write strobe or data hold wrong");
	a_no_write_busy: assert property ($fell(o_write_n) |-> i_store_busy_n)
		else $error("write started while busy low");
	a_pin_req_len: assert property ($fell(o_store_busy_n_oe_n) |->
		(!o_store_busy_n_oe_n)[*5] ##1 o_store_busy_n_oe_n)
		else $error("store request pulse length wrong");
	a_ready_fail: assert property (i_power_fail[*4] |-> !o_req_ready)
		else $error("ready while power failing");
	c_read: cover property ($fell(o_out_drive_n));
	c_write: cover property ($fell(o_write_n));
	c_pin: cover property ($fell(o_store_busy_n_oe_n));
endmodule : nv_sram_store_port_assertions
`default_nettype wire

/* File: bench/nv_sram_dev_model.sv */
/* Behavioural model of the nonvolatile SRAM on the far side.
 Assumes the bench resolves the data and store-busy lines. */
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_map.svh"
module nv_sram_dev_model #(
	parameter int STORE_NS = 400,
	parameter int DELAY_NS = 100
) (
	input wire logic [16:0] i_addr_in,
	input wire logic        i_chip_sel_n,
	input wire logic        i_write_n,
	input wire logic        i_out_drive_n,
	input wire logic [7:0]  i_data_io,
	output logic [7:0]      o_data_io,
	output logic            o_data_oe,
	input wire logic        i_store_busy_n,
	output logic            o_busy_pull,
	input wire logic        i_power_fail,
	output int              o_store_cnt
);
	localparam logic [16:0] SEQ [6] = '{`NV_SW_A0, `NV_SW_A1, `NV_SW_A2,
		`NV_SW_A3, `NV_SW_A4, `NV_SW_STORE};
	logic [7:0] mem [0:131071];
	logic       storing = 1'b0;
	logic       dirty = 1'b0;
	logic       wr_block = 1'b0;
	int         seq_idx = 0;
	wire logic  rd_act = !i_chip_sel_n && i_write_n && i_store_busy_n
		&& !storing;
	wire logic  wr_act = !i_chip_sel_n && !i_write_n && i_store_busy_n && !storing
		&& !wr_block;
	assign o_data_oe = rd_act && !i_out_drive_n;
	assign o_data_io = mem[i_addr_in];
	initial o_busy_pull = 1'b0;
	initial o_store_cnt = 0;
	task automatic store_run();
		storing = 1'b1;
		o_busy_pull = 1'b1;
		#(STORE_NS);
		o_busy_pull = 1'b0;
		storing = 1'b0;
		wr_block = !i_chip_sel_n && !i_write_n;
		dirty = 1'b0;
		o_store_cnt++;
	endtask : store_run
	// A fresh strobe edge lifts the post-store write block
	always @(negedge i_chip_sel_n or negedge i_write_n)
		wr_block = 1'b0;
	always @(negedge wr_act)
	begin
		mem[i_addr_in] = i_data_io;
		dirty = 1'b1;
		seq_idx = 0;
	end
	always @(negedge rd_act)
		if (!storing && i_store_busy_n)
		begin
			seq_idx = (i_addr_in == SEQ[seq_idx]) ? seq_idx + 1 : int'(i_addr_in == SEQ[0]);
			if (seq_idx == 6)
			begin
				seq_idx = 0;
				store_run();
			end
		end
	always @(negedge i_store_busy_n)
		if (!o_busy_pull)
		begin
			#(DELAY_NS);
			if (dirty && !storing)
				store_run();
		end
	always @(posedge i_power_fail)
		if (dirty && !storing)
			store_run();
endmodule : nv_sram_dev_model
`default_nettype wire

/* File: bench/nv_sram_store_port_tb.sv */
/* Self-checking bench for the nonvolatile SRAM host controller.
 Assumes the device model and checker files are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module nv_sram_store_port_tb;
	import nv_host_pkg::*;
	logic clk = 0, rst_n = 0, req_valid = 0, power_fail = 0;
	host_req_t req = '0;
	logic ready, rsp_valid, dirty, sbusy, cs_n, we_n, oe_n, dq_oe_n, hb_n, hb_oe_n, dev_oe, dev_pull;
	logic [7:0] rsp_data, host_dq, dev_dq, bus_dq, last_dq = 8'h00;
	logic [16:0] addr;
	int n_mismatch = 0, checks = 0, cycles = 0, st_cnt, n_store;
	wire logic busy_w = !((!hb_oe_n && !hb_n) || dev_pull);
	always #10 clk = ~clk;
	always @* bus_dq = !dq_oe_n ? host_dq : dev_oe ? dev_dq : ~last_dq;
	always @(posedge clk) last_dq <= bus_dq;
	nv_sram_store_port u_nv_sram_store_port (.i_core_clk(clk), .i_reset_n(rst_n),
		.i_req_valid(req_valid), .i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_dirty(dirty), .o_store_busy(sbusy), .i_power_fail(power_fail),
		.o_addr_in(addr), .o_chip_sel_n(cs_n), .o_write_n(we_n), .o_out_drive_n(oe_n),
		.i_data_io(bus_dq), .o_data_io(host_dq), .o_data_io_oe_n(dq_oe_n),
		.i_store_busy_n(busy_w), .o_store_busy_n(hb_n), .o_store_busy_n_oe_n(hb_oe_n));
	nv_sram_dev_model u_nv_sram_dev_model (.i_addr_in(addr), .i_chip_sel_n(cs_n),
		.i_write_n(we_n), .i_out_drive_n(oe_n), .i_data_io(bus_dq), .o_data_io(dev_dq),
		.o_data_oe(dev_oe), .i_store_busy_n(busy_w), .o_busy_pull(dev_pull),
		.i_power_fail(power_fail), .o_store_cnt(st_cnt));
	task conclude();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task check(input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task req_op(input host_op_t op, input logic [16:0] a, input logic [7:0] d);
		@(posedge clk);
		while (ready !== 1'b1) @(posedge clk);
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, wdata: d};
		@(posedge clk);
		req_valid <= 1'b0;
		do @(posedge clk); while (rsp_valid !== 1'b1);
	endtask : req_op
	task t_read_write();
		req_op(OP_WRITE, 17'h00000, 8'h5a);
		req_op(OP_WRITE, 17'h1ffff, 8'ha5);
		check(dirty, 1'b1);
		req_op(OP_READ, 17'h1ffff, 8'h00);
		check(rsp_data, 8'ha5);
		req_op(OP_READ, 17'h00000, 8'h00);
		check(rsp_data, 8'h5a);
		$display("test read_write done");
	endtask : t_read_write
	task t_pin_store();
		n_store = st_cnt;
		req_op(OP_HWST, 17'h00000, 8'h00);
		check(17'(st_cnt), 17'(n_store + 1));
		check(dirty, 1'b0);
		req_op(OP_HWST, 17'h00000, 8'h00);
		check(17'(st_cnt), 17'(n_store + 1));
		req_op(OP_READ, 17'h1ffff, 8'h00);
		check(rsp_data, 8'ha5);
		$display("test pin_store done");
	endtask : t_pin_store
	task t_sw_store();
		n_store = st_cnt;
		req_op(OP_SWST, 17'h00000, 8'h00);
		check(17'(st_cnt), 17'(n_store + 1));
		$display("test sw_store done");
	endtask : t_sw_store
	task t_power_fail();
		req_op(OP_WRITE, 17'h04e38, 8'h3c);
		n_store = st_cnt;
		power_fail <= 1'b1;
		repeat (10) @(posedge clk);
		check(ready, 1'b0);
		check(sbusy, 1'b1);
		repeat (30) @(posedge clk);
		power_fail <= 1'b0;
		check(17'(st_cnt), 17'(n_store + 1));
		req_op(OP_READ, 17'h04e38, 8'h00);
		check(rsp_data, 8'h3c);
		check(dirty, 1'b0);
		check(sbusy, 1'b0);
		$display("test power_fail done");
	endtask : t_power_fail
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_read_write();
		t_pin_store();
		t_sw_store();
		t_power_fail();
		conclude();
	end
endmodule : nv_sram_store_port_tb
bind nv_sram_store_port nv_sram_store_port_assertions u_nv_sram_store_port_assertions (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_power_fail(i_power_fail),
	.i_store_busy_n(i_store_busy_n), .o_req_ready(o_req_ready), .o_addr_in(o_addr_in),
	.o_chip_sel_n(o_chip_sel_n), .o_write_n(o_write_n), .o_out_drive_n(o_out_drive_n),
	.o_data_io_oe_n(o_data_io_oe_n), .o_store_busy_n_oe_n(o_store_busy_n_oe_n));
`default_nettype wire
